// *** dss_pkg.sv ***
/*
 * Constants shared by the start/stop sequencer: clock and control tick
 * timing, speed scaling, reset values of the stop configuration.
 * Assumes a single 20 MHz clock and one control tick per millisecond.
 */
`default_nettype none

package dss_pkg;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int DSS_CLK_PERIOD_NS  = 50;        // 20 MHz
	localparam int DSS_TICK_PERIOD_NS = 1_000_000; // 1 ms control tick
	localparam int DSS_TICK_CYCLES    =
		DSS_TICK_PERIOD_NS / DSS_CLK_PERIOD_NS;

	// ********************************************************
	// Widths and scaling
	// ********************************************************
	localparam int DSS_SPD_W = 16; // Speed in units of 0.01 %
	localparam int DSS_DUR_W = 16; // Durations in ms ticks

	typedef logic [DSS_SPD_W-1:0] dss_spd_t;
	typedef logic [DSS_DUR_W-1:0] dss_dur_t;

	localparam dss_spd_t DSS_FULL_SCALE = 16'h2710; // 100.00 %
	localparam dss_spd_t DSS_ZERO_SPEED = 16'h0000; // 0 %

	// ********************************************************
	// Stop style and reset values
	// ********************************************************
	localparam logic     DSS_STYLE_RAMP  = 1'h0;
	localparam logic     DSS_STYLE_COAST = 1'h1;
	localparam logic     DSS_STYLE_RESET = DSS_STYLE_RAMP;
	localparam dss_dur_t DSS_FINAL_STOP_MS_RESET = 16'h2710; // 10.0 s

endpackage

`default_nettype wire

// *** dss_sequencer.sv ***
/*
 * Start/stop sequencer of a motor drive: turns keypad and remote run,
 * reverse, jog and stop commands into a velocity_setpoint_out ramp, a trim term
 * and a power-stage enable, with fast-stop, coast-stop and trip overrides.
 * Assumes all inputs synchronous to clk; durations are in ms ticks.
 */
`default_nettype none

module dss_sequencer #(
	parameter int TICK_DIV = dss_pkg::DSS_TICK_CYCLES // Clocks per tick
) (
	input  wire logic              clk,            // 20 MHz clock
	input  wire logic              srst,           // Sync reset, high
	input  wire logic              localMode,      // Keypad sequencing
	input  wire logic              keyRun,         // Keypad run key
	input  wire logic              keyStop,        // Keypad stop key
	input  wire logic              keyJog,         // Keypad jog key
	input  wire logic              keyDirRev,      // Keypad direction
	input  wire logic              runForward,     // Remote run fwd
	input  wire logic              runReverse,     // Remote run rev
	input  wire logic              inch_request,   // Remote jog
	input  wire logic              stop_n,         // Remote not-stop
	input  wire logic              fastStop_n,     // Not fast stop
	input  wire logic              coastStop_n,    // Not coast stop
	input  wire logic              driveEnable,    // Power allowed
	input  wire logic              tripDetect,     // Trip present
	input  wire logic              faultReset,     // Trip reset pulse
	input  wire logic              hold,           // Stop on final ramp
	input  wire logic              trimActive,     // Trim in use
	input  wire logic              cfgLoad,        // Load stop config
	input  wire logic              halt_style_param_tag, // 1 = coast
	input  wire dss_pkg::dss_dur_t finalStopDur,   // Final stop, ms
	input  wire logic              fastStopStyle,  // 1 = coast
	input  wire dss_pkg::dss_dur_t fastStopDur,    // Fast stop, ms
	input  wire dss_pkg::dss_dur_t slowdown_duration, // Decel, ms
	input  wire dss_pkg::dss_dur_t accelDur,       // Accel, ms
	input  wire dss_pkg::dss_dur_t postStopDelay,  // Post-stop, ms
	input  wire dss_pkg::dss_spd_t referenceSpeed, // Run target
	input  wire dss_pkg::dss_spd_t jogSpeed,       // Jog target
	input  wire dss_pkg::dss_spd_t actualSpeed,    // Measured speed
	output var  dss_pkg::dss_spd_t velocity_setpoint_out, // Demand
	output var  dss_pkg::dss_spd_t trimLevel,      // Trim scale
	output var  logic              seq_direction_out, // 1 = reverse
	output logic                   powerEnable,    // Power stage on
	output logic                   running,        // Sequence active
	output logic                   no_fault_indicator // Not tripped
);
	import dss_pkg::*;

	// Elaboration check of the tick divider
	if (TICK_DIV < 1) begin : g_bad_div
		$error("TICK_DIV must be at least one");
	end

	typedef enum logic [2:0] {
		ST_IDLE, ST_RUN, ST_JOG, ST_DECEL, ST_TRIM, ST_POST, ST_FAST
	} dss_state_e;

	// ********************************************************
	// Control tick
	// ********************************************************
	logic [31:0] tickCnt;
	logic        tick;

	// Divider producing one-cycle tick enable
	always_ff @(posedge clk) begin
		if (srst || tickCnt == 32'(TICK_DIV - 1)) begin
			tickCnt <= '0;
		end else begin
			tickCnt <= tickCnt + 32'h1;
		end
	end
	assign tick = (tickCnt == 32'(TICK_DIV - 1));

	// ********************************************************
	// Stop configuration
	// ********************************************************
	logic     stopCoast;
	dss_dur_t finalDur;

	// Captured on load strobe, defaults after reset
	always_ff @(posedge clk) begin
		if (srst) begin
			stopCoast <= DSS_STYLE_RESET;
			finalDur  <= DSS_FINAL_STOP_MS_RESET;
		end else if (cfgLoad) begin
			stopCoast <= halt_style_param_tag;
			finalDur  <= finalStopDur;
		end
	end

	// ********************************************************
	// Command sources
	// ********************************************************
	dss_state_e state;
	logic fwdLatch;
	logic revLatch;
	logic keyLatch;
	logic fwdEff;
	logic revEff;
	logic runReq;
	logic revReq;
	logic jogReq;

	// Remote latches only while not-stop is high
	always_ff @(posedge clk) begin
		if (srst || !stop_n) begin
			fwdLatch <= 1'h0;
			revLatch <= 1'h0;
		end else if (state != ST_JOG && runForward && !runReverse) begin
			fwdLatch <= 1'h1;
			revLatch <= 1'h0;
		end else if (state != ST_JOG && runReverse && !runForward) begin
			fwdLatch <= 1'h0;
			revLatch <= 1'h1;
		end
	end

	// Keypad run latch, stop key clears
	always_ff @(posedge clk) begin
		if (srst || keyStop) begin
			keyLatch <= 1'h0;
		end else if (keyRun && state != ST_JOG) begin
			keyLatch <= 1'h1;
		end
	end

	// One command set whatever the source
	always_comb begin
		// Latched requests count only while not-stop is high
		fwdEff = runForward | (fwdLatch & stop_n);
		revEff = runReverse | (revLatch & stop_n);
		if (localMode) begin
			runReq = keyLatch;
			revReq = keyDirRev;
			jogReq = keyJog;
		end else begin
			runReq = fwdEff ^ revEff;
			revReq = revEff & ~fwdEff;
			jogReq = inch_request;
		end
	end

	// ********************************************************
	// Trip and override conditions
	// ********************************************************
	logic tripped;
	logic coastAct;
	logic fastAct;

	// Trip held until cleared and reset
	always_ff @(posedge clk) begin
		if (srst) begin
			tripped <= 1'h0;
		end else if (tripDetect) begin
			tripped <= 1'h1;
		end else if (faultReset) begin
			tripped <= 1'h0;
		end
	end
	assign no_fault_indicator = !tripped;
	assign coastAct = !coastStop_n || tripped || tripDetect
		|| !driveEnable;
	assign fastAct  = !fastStop_n && !coastAct;

	// ********************************************************
	// Ramp helpers
	// ********************************************************
	function automatic dss_spd_t stepFor(input dss_dur_t dur);
		logic [31:0] q;
		q = 32'(DSS_FULL_SCALE) / ((dur == '0) ? 32'h1 : 32'(dur));
		if (dur == '0)
			q = 32'(DSS_FULL_SCALE);
		if (q == 32'h0)
			q = 32'h1;
		return q[DSS_SPD_W-1:0];
	endfunction

	function automatic dss_spd_t towards(input dss_spd_t cur,
		input dss_spd_t tgt, input dss_spd_t step);
		dss_spd_t res;
		res = cur;
		if (cur < tgt)
			res = (tgt - cur > step) ? cur + step : tgt;
		else if (cur > tgt)
			res = (cur - tgt > step) ? cur - step : tgt;
		return res;
	endfunction

	// ********************************************************
	// Sequence
	// ********************************************************
	logic       useFinal;
	dss_dur_t   delayCnt;
	logic       stopRun;
	logic       stopJog;
	logic       stopFromRun;
	dss_spd_t   decelStep;

	assign stopRun = !runReq || (revReq != seq_direction_out);
	assign stopJog = !jogReq;
	assign stopFromRun = (state == ST_RUN && stopRun)
		|| (state == ST_JOG && stopJog);
	assign decelStep = stepFor(useFinal ? finalDur
		: slowdown_duration);

	// State, demand, trim and post-stop count
	always_ff @(posedge clk) begin
		if (srst) begin
			state                 <= ST_IDLE;
			velocity_setpoint_out <= DSS_ZERO_SPEED;
			trimLevel             <= DSS_ZERO_SPEED;
			seq_direction_out     <= 1'h0;
			useFinal              <= 1'h0;
			delayCnt              <= '0;
		end else if (coastAct) begin
			state                 <= ST_IDLE;
			velocity_setpoint_out <= DSS_ZERO_SPEED;
			trimLevel             <= DSS_ZERO_SPEED;
		end else if (fastAct && state != ST_IDLE && state != ST_POST
			&& state != ST_FAST) begin
			trimLevel <= DSS_ZERO_SPEED;
			if (fastStopStyle == DSS_STYLE_COAST) begin
				state                 <= ST_IDLE;
				velocity_setpoint_out <= DSS_ZERO_SPEED;
			end else begin
				state <= ST_FAST;
			end
		end else if (stopFromRun && stopCoast == DSS_STYLE_COAST) begin
			state                 <= ST_IDLE;
			velocity_setpoint_out <= DSS_ZERO_SPEED;
			trimLevel             <= DSS_ZERO_SPEED;
		end else if (stopFromRun) begin
			state                 <= ST_DECEL;
			velocity_setpoint_out <= actualSpeed;
			useFinal <= (slowdown_duration == '0) || hold;
		end else begin
			unique case (state)
				ST_IDLE: begin
					delayCnt <= '0;
					if (!fastAct && runReq) begin
						state             <= ST_RUN;
						seq_direction_out <= revReq;
						trimLevel         <= DSS_FULL_SCALE;
					end else if (!fastAct && jogReq) begin
						state             <= ST_JOG;
						seq_direction_out <= localMode & keyDirRev;
						trimLevel         <= DSS_FULL_SCALE;
					end
				end
				ST_RUN: begin
					if (tick)
						velocity_setpoint_out <= towards(
							velocity_setpoint_out, referenceSpeed,
							stepFor(accelDur));
				end
				ST_JOG: begin
					if (tick)
						velocity_setpoint_out <= towards(
							velocity_setpoint_out, jogSpeed,
							stepFor(accelDur));
				end
				ST_DECEL: begin
					if (velocity_setpoint_out == DSS_ZERO_SPEED) begin
						if (trimActive && !useFinal) begin
							state <= ST_TRIM;
						end else begin
							state     <= ST_POST;
							trimLevel <= DSS_ZERO_SPEED;
						end
					end else if (tick) begin
						velocity_setpoint_out <= towards(
							velocity_setpoint_out, DSS_ZERO_SPEED,
							decelStep);
					end
				end
				ST_TRIM: begin
					if (trimLevel == DSS_ZERO_SPEED)
						state <= ST_POST;
					else if (tick)
						trimLevel <= towards(trimLevel,
							DSS_ZERO_SPEED, stepFor(finalDur));
				end
				ST_POST: begin
					if (delayCnt >= postStopDelay)
						state <= ST_IDLE;
					else if (tick)
						delayCnt <= delayCnt + 16'h1;
				end
				ST_FAST: begin
					if (velocity_setpoint_out == DSS_ZERO_SPEED)
						state <= ST_POST;
					else if (tick)
						velocity_setpoint_out <= towards(
							velocity_setpoint_out, DSS_ZERO_SPEED,
							stepFor(fastStopDur));
				end
			endcase
		end
	end

	// Power and running status
	assign running     = (state != ST_IDLE);
	assign powerEnable = running && driveEnable;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence sStopRamp;
		state == ST_RUN && stopRun && !coastAct && !fastAct
			&& stopCoast == DSS_STYLE_RAMP;
	endsequence

	sequence sDecelDone;
		state == ST_DECEL && velocity_setpoint_out == DSS_ZERO_SPEED
			&& !coastAct && !fastAct;
	endsequence

	reset_defaults_a: assert property (
		$fell(srst) |-> stopCoast == DSS_STYLE_RAMP
			&& finalDur == DSS_FINAL_STOP_MS_RESET)
		else $error("stop config not at reset values");

	ramp_stop_entry_a: assert property (
		sStopRamp |=> state == ST_DECEL
			&& velocity_setpoint_out == $past(actualSpeed))
		else $error("ramp stop did not start from actual speed");

	no_trim_post_a: assert property (
		sDecelDone and (!trimActive) |=> state == ST_POST)
		else $error("decel without trim did not end stop ramp");

	post_delay_a: assert property (
		state == ST_POST && driveEnable |-> powerEnable)
		else $error("power dropped during post-stop delay");

	coast_style_a: assert property (
		stopFromRun && stopCoast == DSS_STYLE_COAST && !coastAct
			&& !fastAct |=> state == ST_IDLE && !powerEnable
			&& velocity_setpoint_out == DSS_ZERO_SPEED)
		else $error("coast style stop not immediate");

	fast_stop_a: assert property (
		state == ST_RUN && fastAct |=> state == ST_FAST
			|| state == ST_IDLE)
		else $error("fast stop not taken from run");

	coast_stop_a: assert property (
		!coastStop_n |=> !powerEnable ##1 !powerEnable)
		else $error("coast stop left power enabled");

	coast_priority_a: assert property (
		!coastStop_n |=> state != ST_FAST)
		else $error("fast stop acted during coast stop");

	trip_hold_a: assert property (
		tripped && !faultReset |=> tripped && !powerEnable)
		else $error("trip released without reset");

	enable_gate_a: assert property (
		!driveEnable |-> !powerEnable)
		else $error("power on without drive enable");

	two_wire_a: assert property (
		!localMode && runForward && runReverse && state == ST_RUN
			|=> state != ST_RUN)
		else $error("run and reverse together kept running");

	jog_release_a: assert property (
		state == ST_JOG && !jogReq |=> state != ST_JOG)
		else $error("jog continued after release");

	run_jog_excl_a: assert property (
		state == ST_JOG |-> $past(state) inside {ST_IDLE, ST_JOG})
		else $error("jog entered without stopping");

	no_fault_indicator_a: assert property (
		tripDetect |=> !no_fault_indicator)
		else $error("no_fault_indicator stayed true after trip");

endmodule

`default_nettype wire

// *** dss_switch_model.sv ***
/*
 * Model of the operator keypad and the remote run/stop switch contacts
 * that feed the start/stop sequencer.
 * Assumes the bench changes cmd on the falling clock edge only.
 */
`default_nettype none

module dss_switch_model (
	input  wire logic [7:0] cmd,          // Requested contact states
	output logic            runForward,   // Remote run fwd
	output logic            runReverse,   // Remote run rev
	output logic            inch_request, // Remote jog
	output logic            keyRun,       // Keypad run key
	output logic            keyStop,      // Keypad stop key
	output logic            keyDirRev,    // Keypad direction
	output logic            stop_n        // Remote not-stop
);
	timeunit 1ns;
	timeprecision 1ns;

	// ********************************************************
	// Contacts
	// ********************************************************
	// Stop held closed only as long as asked; enable never used to start
	always_comb begin
		{keyDirRev, keyStop, keyRun} = cmd[6:4];
		{inch_request, runReverse, runForward} = cmd[2:0];
		stop_n = ~cmd[7];
	end
endmodule

`default_nettype wire

// *** dss_sequencer_tb.sv ***
/*
 * Self-checking bench of the start/stop sequencer: ramped, coasting,
 * forced and trip stops, latching and jog, random speeds.
 * Assumes dss_pkg and dss_switch_model are compiled first.
 */
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module dss_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dss_pkg::*;

	localparam int TD = 4;
	int       seed = 32'h8d2ee247;
	int       fails = 0, tests_run = 0, cycles = 0;
	int       wt, wn;
	logic     clk = 1'h0, srst = 1'h1, localMode = 1'h0, keyJog = 1'h0;
	logic     fastStop_n = 1'h1, coastStop_n = 1'h1, driveEnable = 1'h1;
	logic     tripDetect = 1'h0, faultReset = 1'h0, hold = 1'h0;
	logic     cfgLoad = 1'h0, halt_style_param_tag = 1'h0;
	logic     fastStopStyle = 1'h0, trimActive = 1'h0;
	logic     [7:0] cmd = 8'h00;
	dss_dur_t finalStopDur = 16'h0014, slowdown_duration = 16'h000a;
	dss_dur_t fastStopDur = 16'h000a, accelDur = 16'h000a;
	dss_dur_t postStopDelay = 16'h0005;
	dss_spd_t referenceSpeed = 16'h1388, jogSpeed = 16'h03e8;
	dss_spd_t actualSpeed = 16'h0000;
	dss_spd_t velocity_setpoint_out, trimLevel;
	logic     runForward, runReverse, inch_request, keyRun, keyStop;
	logic     keyDirRev, stop_n, seq_direction_out, powerEnable, running;
	logic     no_fault_indicator;

	// ********************************************************
	// Clock, partner and design
	// ********************************************************
	// 20 MHz clock
	always #25 clk = ~clk;

	dss_switch_model i_dss_switch_model (.cmd, .runForward, .runReverse,
		.inch_request, .keyRun, .keyStop, .keyDirRev, .stop_n);

	dss_sequencer #(.TICK_DIV(TD)) i_dss_sequencer (.clk, .srst,
		.localMode, .keyRun, .keyStop, .keyJog, .keyDirRev, .runForward,
		.runReverse, .inch_request, .stop_n, .fastStop_n, .coastStop_n,
		.driveEnable, .tripDetect, .faultReset, .hold, .trimActive,
		.cfgLoad, .halt_style_param_tag, .finalStopDur, .fastStopStyle,
		.fastStopDur, .slowdown_duration, .accelDur, .postStopDelay,
		.referenceSpeed, .jogSpeed, .actualSpeed, .velocity_setpoint_out,
		.trimLevel, .seq_direction_out, .powerEnable, .running,
		.no_fault_indicator);

	// ********************************************************
	// Tasks
	// ********************************************************
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			conclude();
		end
	end

	task automatic waitRun(input logic v, input int lim);
		int k;
		k = 0;
		while (running !== v && k < lim) begin
			cyc(1);
			k++;
		end
		`CHK(running, v)
	endtask

	// Cycles until the demand reaches a value, at most lim
	task automatic waitSpd(input dss_spd_t v, input int lim, output int k);
		k = 0;
		while (velocity_setpoint_out !== v && k < lim) begin
			cyc(1);
			k++;
		end
	endtask

	// Momentary press then release
	task automatic press(input logic [7:0] c);
		cmd = c;
		cyc(1);
		cmd = 8'h00;
	endtask

	task automatic start(input logic [7:0] c);
		press(c);
		waitRun(1'h1, 6);
	endtask

	task automatic cfg(input logic s, input dss_dur_t d);
		halt_style_param_tag = s;
		finalStopDur = d;
		cfgLoad = 1'h1;
		cyc(1);
		cfgLoad = 1'h0;
	endtask

	// Expected ramp length in ticks from duration and start speed
	function automatic int rampTicks(input int dur, input int spd);
		int st;
		st = (dur == 0) ? 10000 : 10000 / dur;
		if (st < 1)
			st = 1;
		return (spd + st - 1) / st;
	endfunction

	task automatic stopRamp(input int dur, input int act,
		input logic [7:0] rc, input logic [7:0] sc);
		int k, n;
		k = 0;
		referenceSpeed = dss_spd_t'(1000 + $unsigned($random(seed)) % 9000);
		actualSpeed = dss_spd_t'(act);
		start(rc);
		n = rampTicks(10, referenceSpeed) * TD + 6;
		while (velocity_setpoint_out !== referenceSpeed && k < n) begin
			cyc(1);
			k++;
		end
		`CHK(velocity_setpoint_out, referenceSpeed)
		press(sc);
		n = rampTicks(dur, act);
		k = 0;
		while (velocity_setpoint_out !== 16'h0000 && k < n * TD + 10) begin
			cyc(1);
			k++;
		end
		`CHK(k + 1 >= (n - 1) * TD && k <= n * TD + 3, 1'h1)
		`CHK(powerEnable, 1'h1)
		waitRun(1'h0, (postStopDelay + 3) * TD);
		`CHK(powerEnable, 1'h0)
		`CHK(trimLevel, 16'h0000)
		$display("test done: ramp stop dur %0d", dur);
	endtask

	// Stop pulse clears latches, then wait for idle
	task automatic idle();
		press(8'h80);
		cyc(1);
		waitRun(1'h0, 200);
	endtask

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		cyc(3);
		srst = 1'h0;
		cyc(1);
		`CHK(velocity_setpoint_out, 16'h0000)
		`CHK({running, powerEnable, no_fault_indicator}, 3'h1)
		hold = 1'h1;
		stopRamp(10000, 8, 8'h01, 8'h80);
		hold = 1'h0;
		cfg(1'h0, 16'h0014);
		slowdown_duration = 16'h0000;
		stopRamp(20, 1 + $unsigned($random(seed)) % 9000, 8'h01, 8'h80);
		slowdown_duration = 16'h000a;
		repeat (2)
			stopRamp(10, 1 + $unsigned($random(seed)) % 9000, 8'h01, 8'h80);
		// Trim term ramps out after the speed ramp
		trimActive = 1'h1;
		start(8'h01);
		press(8'h80);
		waitSpd(16'h0000, 60, wt);
		`CHK(trimLevel, DSS_FULL_SCALE)
		wn = rampTicks(20, 10000);
		wt = 0;
		while (trimLevel !== 16'h0000 && wt < 100) begin
			cyc(1);
			wt++;
		end
		`CHK(wt >= (wn - 1) * TD && wt <= wn * TD + 2, 1'h1)
		`CHK(powerEnable, 1'h1)
		waitRun(1'h0, (postStopDelay + 3) * TD);
		trimActive = 1'h0;
		$display("test done: trim ramp");
		localMode = 1'h1;
		stopRamp(10, 3000, 8'h10, 8'h20);
		localMode = 1'h0;
		// Coasting stop style
		cfg(1'h1, 16'h0014);
		start(8'h01);
		press(8'h80);
		cyc(1);
		`CHK({powerEnable, velocity_setpoint_out}, 17'h0)
		cfg(1'h0, 16'h0014);
		$display("test done: coast style");
		// Coast stop beats ramped fast stop
		start(8'h01);
		{coastStop_n, fastStop_n} = 2'h0;
		cyc(2);
		`CHK(powerEnable, 1'h0)
		{coastStop_n, fastStop_n} = 2'h3;
		idle();
		// Fast stop in coast style refuses starts
		fastStopStyle = 1'h1;
		start(8'h01);
		fastStop_n = 1'h0;
		cyc(2);
		`CHK(powerEnable, 1'h0)
		press(8'h01);
		cyc(3);
		`CHK(running, 1'h0)
		idle();
		fastStop_n = 1'h1;
		fastStopStyle = 1'h0;
		// Ramped fast stop over the fast stop duration
		start(8'h01);
		waitSpd(referenceSpeed, 60, wt);
		fastStop_n = 1'h0;
		wn = rampTicks(10, referenceSpeed);
		waitSpd(16'h0000, 60, wt);
		`CHK(wt >= (wn - 1) * TD && wt <= wn * TD + 2, 1'h1)
		`CHK({running, trimLevel}, 17'h10000)
		waitRun(1'h0, (postStopDelay + 3) * TD);
		idle();
		fastStop_n = 1'h1;
		$display("test done: forced stops");
		// Trip holds until reset
		start(8'h01);
		tripDetect = 1'h1;
		cyc(2);
		tripDetect = 1'h0;
		`CHK({powerEnable, no_fault_indicator}, 2'h0)
		idle();
		press(8'h01);
		cyc(3);
		`CHK(running, 1'h0)
		idle();
		faultReset = 1'h1;
		cyc(1);
		faultReset = 1'h0;
		cyc(1);
		`CHK(no_fault_indicator, 1'h1)
		start(8'h01);
		idle();
		$display("test done: trip");
		// Run and reverse together
		cmd = 8'h03;
		cyc(4);
		`CHK(running, 1'h0)
		cmd = 8'h00;
		idle();
		// Drive enable removed
		start(8'h02);
		`CHK(seq_direction_out, 1'h1)
		driveEnable = 1'h0;
		#1;
		`CHK(powerEnable, 1'h0)
		idle();
		press(8'h01);
		cyc(3);
		`CHK(running, 1'h0)
		idle();
		driveEnable = 1'h1;
		// Jog only while held, run ignored while jogging
		cmd = 8'h04;
		waitRun(1'h1, 6);
		cyc(2 * TD);
		cmd = 8'h05;
		cyc(1);
		cmd = 8'h00;
		waitRun(1'h0, 200);
		cyc(3);
		`CHK(running, 1'h0)
		// Keypad jog in reverse, only while held
		localMode = 1'h1;
		cmd = 8'h40;
		keyJog = 1'h1;
		waitRun(1'h1, 6);
		`CHK(seq_direction_out, 1'h1)
		keyJog = 1'h0;
		waitRun(1'h0, 200);
		cmd = 8'h00;
		localMode = 1'h0;
		$display("test done: enable and jog");
		conclude();
	end
endmodule

`undef CHK

`default_nettype wire
